//--- rtl/emsd_top.sv
// Purpose: address-space decode and external select strobes of the core
// Assumes: one request at a time from the core, held until taken
// Notes:   pins ready_pin and data_in pass two flip-flops before use
//
// Overview of operation
// - on-chip program fetches keep program select and strobe high
// - external buses move only for addresses mapped outside the chip
// - program select goes low for external program cycles
// - strobe goes low for every external cycle, memory or io
// - external cycles stretch by wait count and the ready pin
// - program space spans 64K words on a 16-bit address
// - block of 256 words sits in program or data space
// - blocks of 256 and 32 words are data memory only
// - direct address is page pointer joined to 7-bit offset
// - mask, allocation and flag registers at 0004h-0006h, no waits
// - scratch-pad block answers at 0060h through 007Fh
// - on-chip data and register accesses keep data select high
// - data select goes low for external local or global data
// - only upper-half data addresses may become global
// - allocation register is eight bits on the low data byte
// - each added leading one halves the global region
// - upper-half addresses outside global region stay local
// - any external data access drives data select low
// - global accesses assert bus request with data select
`timescale 1ns/1ns
`default_nettype none
module emsd_top
    import emsd_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire emsd_req_t        req,
    output logic                  resp_valid,
    output logic     [DW-1:0]     resp_rdata,
    input  wire logic [DP_W-1:0]  page_pointer,
    input  wire logic             b0_in_program,
    input  wire logic [WAIT_W-1:0] wait_states,
    input  wire logic [DW-1:0]    irq_events,
    output logic     [DW-1:0]     interrupt_mask,
    output logic     [DW-1:0]     interrupt_flags,
    input  wire logic             ready_pin,
    output logic     [AW-1:0]     ext_addr,
    input  wire logic [DW-1:0]    data_in,
    output logic     [DW-1:0]     data_out,
    output logic                  data_oe,
    output emsd_sel_t             ext_sel
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic          rdy_meta_q, rdy_sync_q;
    logic [DW-1:0] din_meta_q, din_sync_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdy_meta_q <= 1'b1;
            rdy_sync_q <= 1'b1;
            din_meta_q <= '0;
            din_sync_q <= '0;
        end else begin
            rdy_meta_q <= ready_pin;
            rdy_sync_q <= rdy_meta_q;
            din_meta_q <= data_in;
            din_sync_q <= din_meta_q;
        end
    end

    // ------------------------------------------------------------
    // address decode of the offered request
    // ------------------------------------------------------------
    emsd_state_t   state_q;
    logic [7:0]    global_space_allocation_q;
    logic [AW-1:0] eff_addr;
    logic          is_data, is_prog, in_b0, in_b1, in_b2, in_page0;
    logic          on_chip, is_glob, accept;
    emsd_src_t     src_d;

    assign is_data = (req.space == EMSD_SP_DATA);
    assign is_prog = (req.space == EMSD_SP_PROG);
    assign eff_addr = (is_data && req.direct) ?
                      {page_pointer, req.offset} : req.addr;
    assign in_b1 = is_data && (eff_addr[15:8] == B1_BASE[15:8]);
    assign in_b2 = is_data && (eff_addr[15:5] == B2_BASE[15:5]);
    // remainder of page 0 stays inside
    assign in_page0 = is_data && (eff_addr[15:7] == '0);
    assign in_b0 = b0_in_program ?
                   (is_prog && eff_addr[15:8] == B0_PROG_BASE[15:8]) :
                   (is_data && eff_addr[15:8] == B0_DATA_BASE[15:8]);
    assign on_chip = in_b0 || in_b1 || in_page0;
    assign is_glob = is_data && eff_addr[15] && (global_space_allocation_q != '0) &&
                     ((eff_addr[15:8] & global_space_allocation_q) == global_space_allocation_q);
    assign req_ready = (state_q == EMSD_ST_IDLE);
    assign accept    = req_valid && req_ready;

    always_comb begin
        if (in_b2) begin
            src_d = EMSD_SRC_B2;
        end else if (in_b1) begin
            src_d = EMSD_SRC_B1;
        end else if (in_b0) begin
            src_d = EMSD_SRC_B0;
        end else begin
            src_d = EMSD_SRC_REG;
        end
    end

    // ------------------------------------------------------------
    // on-chip memories
    // ------------------------------------------------------------
    logic [DW-1:0] b0_rd, b1_rd, b2_rd;
    logic          mem_we;

    assign mem_we = accept && req.write;

    emsd_ram #(.WORDS(B0_WORDS), .DW(DW)) u_b0 (
        .core_clk (core_clk),
        .en       (accept && in_b0),
        .we       (mem_we),
        .addr     (eff_addr[$clog2(B0_WORDS)-1:0]),
        .wdata    (req.wdata),
        .rdata    (b0_rd)
    );
    emsd_ram #(.WORDS(B1_WORDS), .DW(DW)) u_b1 (
        .core_clk (core_clk),
        .en       (accept && in_b1),
        .we       (mem_we),
        .addr     (eff_addr[$clog2(B1_WORDS)-1:0]),
        .wdata    (req.wdata),
        .rdata    (b1_rd)
    );
    emsd_ram #(.WORDS(B2_WORDS), .DW(DW)) u_b2 (
        .core_clk (core_clk),
        .en       (accept && in_b2),
        .we       (mem_we),
        .addr     (eff_addr[$clog2(B2_WORDS)-1:0]),
        .wdata    (req.wdata),
        .rdata    (b2_rd)
    );

    // ------------------------------------------------------------
    // memory-mapped registers of page 0
    // ------------------------------------------------------------
    logic          reg_wr;
    logic [DW-1:0] reg_rd_q;

    assign reg_wr = accept && req.write && in_page0 && !in_b2;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            interrupt_mask <= IMASK_RST;
        end else if (reg_wr && eff_addr == ADDR_IMASK) begin
            interrupt_mask <= req.wdata;
        end
    end

    // low byte only, high byte dropped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            global_space_allocation_q <= GLOBAL_SPACE_ALLOCATION_RST;
        end else if (reg_wr && eff_addr == ADDR_GLOBAL_SPACE_ALLOCATION) begin
            global_space_allocation_q <= req.wdata[GLOBAL_SPACE_ALLOCATION_W-1:0];
        end
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            interrupt_flags <= IFLAG_RST;
        end else if (reg_wr && eff_addr == ADDR_IFLAG) begin
            interrupt_flags <= (interrupt_flags & ~req.wdata) | irq_events;
        end else begin
            interrupt_flags <= interrupt_flags | irq_events;
        end
    end

    // reserved page 0 words read zero; writes there are dropped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rd_q <= '0;
        end else if (accept) begin
            case (eff_addr)
                ADDR_IMASK: reg_rd_q <= interrupt_mask;
                ADDR_GLOBAL_SPACE_ALLOCATION:  reg_rd_q <= {8'h00, global_space_allocation_q};
                ADDR_IFLAG: reg_rd_q <= interrupt_flags;
                default:    reg_rd_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    emsd_src_t         src_q;
    logic [WAIT_W-1:0] wait_q;
    logic              ext_done;

    // count down, then hold for the ready pin
    assign ext_done = (state_q == EMSD_ST_EXT) && (wait_q == '0) &&
                      rdy_sync_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= EMSD_ST_IDLE;
        end else begin
            case (state_q)
                EMSD_ST_IDLE: begin
                    if (accept) begin
                        state_q <= (on_chip || in_b2) ? EMSD_ST_INT
                                                      : EMSD_ST_EXT;
                    end
                end
                EMSD_ST_INT: state_q <= EMSD_ST_IDLE;
                EMSD_ST_EXT: begin
                    if (ext_done) begin
                        state_q <= EMSD_ST_IDLE;
                    end
                end
                default: state_q <= EMSD_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wait_q <= '0;
            src_q  <= EMSD_SRC_REG;
        end else if (accept) begin
            wait_q <= wait_states;
            src_q  <= src_d;
        end else if (state_q == EMSD_ST_EXT && wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // external pins
    // ------------------------------------------------------------
    // strobes only for off-chip targets
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_sel  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            ext_addr <= '0;
            data_out <= '0;
            data_oe  <= 1'b0;
        end else if (accept && !(on_chip || in_b2)) begin
            // program select on external program cycles
            ext_sel.ps_n   <= !is_prog;
            // data select on any external data cycle
            ext_sel.ds_n   <= !is_data;
            // bus request paired with data select
            ext_sel.br_n   <= !is_glob;
            ext_sel.is_n   <= (req.space != EMSD_SP_IO);
            ext_sel.access_strobe_n_n <= 1'b0;
            ext_sel.rnw    <= !req.write;
            ext_addr       <= eff_addr;
            data_out       <= req.wdata;
            data_oe        <= req.write;
        end else if (ext_done) begin
            ext_sel <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            data_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // answer to the core
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_rdata <= '0;
        end else begin
            resp_valid <= (state_q == EMSD_ST_INT) || ext_done;
            if (ext_done) begin
                resp_rdata <= din_sync_q;
            end else if (state_q == EMSD_ST_INT) begin
                case (src_q)
                    EMSD_SRC_B0: resp_rdata <= b0_rd;
                    EMSD_SRC_B1: resp_rdata <= b1_rd;
                    EMSD_SRC_B2: resp_rdata <= b2_rd;
                    default:     resp_rdata <= reg_rd_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    onchip_quiet_a: assert property (
        state_q == EMSD_ST_INT |-> ext_sel.ps_n && ext_sel.access_strobe_n_n &&
        ext_sel.ds_n) else $error("select active on on-chip access");
    bus_idle_a: assert property (
        state_q != EMSD_ST_EXT |-> ext_sel.access_strobe_n_n && !data_oe)
        else $error("external bus active outside external cycle");
    prog_select_a: assert property (
        accept && is_prog && !on_chip |=> !ext_sel.ps_n && !ext_sel.access_strobe_n_n)
        else $error("program select missing on external fetch");
    strobe_hold_a: assert property (
        state_q == EMSD_ST_EXT |-> !ext_sel.access_strobe_n_n)
        else $error("strobe high during external cycle");
    wait_count_a: assert property (
        state_q == EMSD_ST_EXT && (wait_q != '0 || !rdy_sync_q)
        |=> state_q == EMSD_ST_EXT && !resp_valid)
        else $error("external cycle ended before wait states");
    direct_addr_a: assert property (
        accept && is_data && req.direct && !on_chip && !in_b2
        |=> ext_addr == {$past(page_pointer), $past(req.offset)})
        else $error("direct address not page and offset");
    reg_zero_wait_a: assert property (
        accept && !req.write && in_page0 && eff_addr == ADDR_GLOBAL_SPACE_ALLOCATION
        |=> ##1 resp_valid && resp_rdata == {8'h00, global_space_allocation_q})
        else $error("allocation register read not immediate");
    scratch_pad_a: assert property (
        accept && in_b2 |=> state_q == EMSD_ST_INT)
        else $error("scratch-pad access went off chip");
    global_space_allocation_write_a: assert property (
        reg_wr && eff_addr == ADDR_GLOBAL_SPACE_ALLOCATION |=> global_space_allocation_q == $past(req.wdata[7:0]))
        else $error("allocation register not written");
    global_pair_a: assert property (
        !ext_sel.br_n |-> !ext_sel.ds_n && !ext_sel.access_strobe_n_n)
        else $error("bus request without data select");
    global_upper_a: assert property (
        accept && is_glob && !on_chip |=> ext_addr[15] && !ext_sel.br_n)
        else $error("global access outside upper half");

    ext_prog_c:  cover property (accept && is_prog && !on_chip);
    ext_glob_c:  cover property (accept && is_glob && !on_chip);
    onchip_c:    cover property (accept && in_b2 ##2 resp_valid);
    wait_seen_c: cover property (state_q == EMSD_ST_EXT && !rdy_sync_q);
endmodule
`default_nettype wire

//--- rtl/emsd_pkg.sv
// Purpose: shared constants and types of the memory space decoder
// Assumes: 16-bit address and data, single core clock
// Notes:   on-chip block bases are placement choices, see hand-over
package emsd_pkg;

    // ------------------------------------------------------------
    // widths and block sizes
    // ------------------------------------------------------------
    localparam int AW        = 16;
    localparam int DW        = 16;
    localparam int DP_W      = 9;
    localparam int OFS_W     = 7;
    localparam int GLOBAL_SPACE_ALLOCATION_W    = 8;
    localparam int B0_WORDS  = 256;
    localparam int B1_WORDS  = 256;
    localparam int B2_WORDS  = 32;
    localparam int WAIT_W    = 3;

    // ------------------------------------------------------------
    // data page 0 registers and block placement
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_IMASK  = 16'h0004;
    localparam logic [15:0] ADDR_GLOBAL_SPACE_ALLOCATION   = 16'h0005;
    localparam logic [15:0] ADDR_IFLAG  = 16'h0006;
    localparam logic [15:0] B2_BASE     = 16'h0060;
    localparam logic [15:0] B1_BASE     = 16'h0300;
    localparam logic [15:0] B0_DATA_BASE = 16'h0200;
    localparam logic [15:0] B0_PROG_BASE = 16'hff00;
    localparam logic [15:0] IMASK_RST   = 16'h0000;
    localparam logic [7:0]  GLOBAL_SPACE_ALLOCATION_RST    = 8'h00;
    localparam logic [15:0] IFLAG_RST   = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EMSD_SP_PROG = 2'h0,
        EMSD_SP_DATA = 2'h1,
        EMSD_SP_IO   = 2'h2
    } emsd_space_t;

    typedef enum logic [1:0] {
        EMSD_SRC_B0  = 2'h0,
        EMSD_SRC_B1  = 2'h1,
        EMSD_SRC_B2  = 2'h2,
        EMSD_SRC_REG = 2'h3
    } emsd_src_t;

    typedef enum logic [1:0] {
        EMSD_ST_IDLE = 2'b00,
        EMSD_ST_INT  = 2'b01,
        EMSD_ST_EXT  = 2'b11
    } emsd_state_t;

    typedef struct packed {
        emsd_space_t      space;
        logic             write;
        logic             direct;
        logic [OFS_W-1:0] offset;
        logic [AW-1:0]    addr;
        logic [DW-1:0]    wdata;
    } emsd_req_t;

    typedef struct packed {
        logic ps_n;
        logic ds_n;
        logic br_n;
        logic is_n;
        logic access_strobe_n_n;
        logic rnw;
    } emsd_sel_t;

endpackage

//--- rtl/emsd_ram.sv
// Purpose: single-port on-chip word memory with registered read data
// Assumes: write and read share one address per cycle
// Notes:   read data show the old word on a write cycle
`timescale 1ns/1ns
`default_nettype none
module emsd_ram #(
    parameter int WORDS = 256,
    parameter int DW    = 16
) (
    input  wire logic                     core_clk,
    input  wire logic                     en,
    input  wire logic                     we,
    input  wire logic [$clog2(WORDS)-1:0] addr,
    input  wire logic [DW-1:0]            wdata,
    output logic      [DW-1:0]            rdata
);
    logic [DW-1:0] mem_q [WORDS];

    always_ff @(posedge core_clk) begin
        if (en && we) begin
            mem_q[addr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (en) begin
            rdata <= mem_q[addr];
        end
    end
endmodule
`default_nettype wire

//--- sim/emsd_sram_model.sv
// Purpose: external static memories and ready logic on the parallel bus
// Assumes: one word array keyed by select kind and address
// Notes:   unselected data pins toggle, so a stale word never passes
`timescale 1ns/1ns
`default_nettype none
module emsd_sram_model
    import emsd_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic [2:0]    stall,
    input  wire logic [AW-1:0] ext_addr,
    input  wire logic [DW-1:0] data_out,
    input  wire logic          data_oe,
    input  wire emsd_sel_t     ext_sel,
    output logic      [DW-1:0] data_in,
    output logic               ready_pin
);
    logic [DW-1:0] mem [logic [18:0]];
    logic [18:0]   key;
    logic [2:0]    cnt;
    logic          act;

    initial begin
        data_in = 16'h5a5a;
        ready_pin = 1'b1;
        cnt = 3'h0;
        act = 1'b0;
    end

    // selects settle after the rising edge, so look at them on the falling
    always @(negedge core_clk) begin
        key = {~ext_sel.br_n, ~ext_sel.is_n, ~ext_sel.ps_n, ext_addr};
        if (ext_sel.access_strobe_n_n) begin
            act = 1'b0;
            ready_pin <= 1'b1;
            data_in <= ~data_in;
        end else begin
            if (!act) begin
                cnt = stall;
            end
            act = 1'b1;
            ready_pin <= (cnt == 3'h0);
            if (cnt != 3'h0) begin
                cnt = cnt - 3'h1;
            end
            if (ext_sel.rnw) begin
                data_in <= mem.exists(key) ? mem[key] : 16'h0000;
            end else if (data_oe) begin
                mem[key] = data_out;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: self-checking bench of the memory space decoder
// Assumes: one request at a time, driven on the falling edge
// Notes:   select check folds every strobe low seen during a request
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import emsd_pkg::*;
    // seen pattern {ps,ds,br,is,access_strobe_n}, a bit low if it went low
    localparam logic [4:0] S_INT = 5'h1f;
    localparam logic [4:0] S_PRG = 5'h0e;
    localparam logic [4:0] S_DAT = 5'h16;
    localparam logic [4:0] S_GLB = 5'h12;
    localparam logic [4:0] S_IO  = 5'h1c;
    typedef struct packed {
        logic        chk;
        logic [15:0] data;
        logic [4:0]  sel;
        logic [15:0] addr;
    } emsd_exp_t;

    logic          core_clk = 1'b0;
    logic          rst, req_valid, req_ready, resp_valid, b0_in_program;
    logic          ready_pin, data_oe;
    emsd_req_t     req;
    emsd_sel_t     ext_sel;
    logic [15:0]   resp_rdata, irq_events, interrupt_mask, interrupt_flags;
    logic [15:0]   ext_addr, data_in, data_out, last, v, a;
    logic [8:0]    page_pointer;
    logic [2:0]    wait_states, stall;
    logic [7:0]    g;
    logic [4:0]    seen = 5'h1f;
    logic [15:0]   seen_addr;
    emsd_exp_t     exp_q[$];
    emsd_exp_t     e;
    integer        seed = 32'he82c;
    int            n_mismatch = 0;
    int            compares = 0;

    always #20 core_clk = ~core_clk;

    emsd_top uut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .page_pointer(page_pointer),
        .b0_in_program(b0_in_program), .wait_states(wait_states),
        .irq_events(irq_events), .interrupt_mask(interrupt_mask),
        .interrupt_flags(interrupt_flags), .ready_pin(ready_pin),
        .ext_addr(ext_addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .ext_sel(ext_sel));

    emsd_sram_model mem_model (.core_clk(core_clk), .stall(stall),
        .ext_addr(ext_addr), .data_out(data_out), .data_oe(data_oe),
        .ext_sel(ext_sel), .data_in(data_in), .ready_pin(ready_pin));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // direct requests carry a wrong full address the design must ignore
    task automatic do_req(input emsd_space_t sp, input logic wr,
                          input logic dir, input logic [15:0] ad,
                          input logic [15:0] d, input logic [4:0] sel);
        emsd_exp_t x;
        @(negedge core_clk);
        x = '{chk: !wr, data: d, sel: sel, addr: ad};
        exp_q.push_back(x);
        req.space = sp;
        req.write = wr;
        req.direct = dir;
        req.offset = ad[6:0];
        req.addr = dir ? ~ad : ad;
        req.wdata = wr ? d : 16'($random(seed));
        wait_states = wr ? 3'($random(seed)) : 3'h2 | 3'($random(seed));
        stall = 3'($random(seed)) & 3'h3;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask

    task automatic wr_rd(input emsd_space_t sp, input logic dir,
                         input logic [15:0] ad, input logic [4:0] sel);
        last = 16'($random(seed));
        do_req(sp, 1'b1, dir, ad, last, sel);
        do_req(sp, 1'b0, dir, ad, last, sel);
    endtask

    // the next request raises its strobes one edge after the edge that answers
    // this one, yet settle the answer before folding in the new selects
    always @(negedge core_clk) begin
        if (resp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                if (e.chk) check(resp_rdata, e.data);
                check(seen, e.sel);
                if (e.sel != S_INT) check(seen_addr, e.addr);
            end
            seen = S_INT;
        end
        if (ext_sel.access_strobe_n_n === 1'b0) seen_addr = ext_addr;
        seen = seen & {ext_sel.ps_n, ext_sel.ds_n, ext_sel.br_n,
                       ext_sel.is_n, ext_sel.access_strobe_n_n};
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        page_pointer = 9'h000;
        b0_in_program = 1'b0;
        wait_states = 3'h0;
        stall = 3'h0;
        irq_events = 16'h0000;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        check(ext_sel, 6'h3f);
        check(interrupt_flags, IFLAG_RST);
        do_req(EMSD_SP_DATA, 1'b0, 1'b0, ADDR_GLOBAL_SPACE_ALLOCATION, 16'h0000, S_INT);
        wr_rd(EMSD_SP_DATA, 1'b0, ADDR_IMASK, S_INT);
        check(interrupt_mask, last);
        do_req(EMSD_SP_DATA, 1'b1, 1'b0, ADDR_GLOBAL_SPACE_ALLOCATION, 16'h12e0, S_INT);
        do_req(EMSD_SP_DATA, 1'b0, 1'b0, ADDR_GLOBAL_SPACE_ALLOCATION, 16'h00e0, S_INT);
        v = 16'($random(seed));
        irq_events = v;
        @(negedge core_clk);
        irq_events = 16'h0000;
        check(interrupt_flags, v);
        do_req(EMSD_SP_DATA, 1'b1, 1'b0, ADDR_IFLAG, 16'h00ff, S_INT);
        do_req(EMSD_SP_DATA, 1'b0, 1'b0, ADDR_IFLAG, v & 16'hff00, S_INT);
        do_req(EMSD_SP_DATA, 1'b0, 1'b0, 16'h002b, 16'h0000, S_INT);
        do_req(EMSD_SP_DATA, 1'b1, 1'b0, 16'h0003, 16'hffff, S_INT);
        do_req(EMSD_SP_DATA, 1'b0, 1'b0, 16'h0003, 16'h0000, S_INT);
        for (int k = 0; k < 9; k++) begin
            g = 8'(16'hff00 >> k);
            do_req(EMSD_SP_DATA, 1'b1, 1'b0, ADDR_GLOBAL_SPACE_ALLOCATION, {8'h5a, g}, S_INT);
            a = (g == 8'h00) ? 16'h8000 : {g, 8'h00};
            wr_rd(EMSD_SP_DATA, 1'b0, a, (g != 0) ? S_GLB : S_DAT);
            wr_rd(EMSD_SP_DATA, 1'b0, a - 16'h1, S_DAT);
            wr_rd(EMSD_SP_DATA, 1'b0, 16'hffff, (g != 0) ? S_GLB : S_DAT);
        end
        // a listed pattern only, away from the region edges
        do_req(EMSD_SP_DATA, 1'b1, 1'b0, ADDR_GLOBAL_SPACE_ALLOCATION, 16'h00c0, S_INT);
        wr_rd(EMSD_SP_DATA, 1'b0, 16'hc123, S_GLB);
        wr_rd(EMSD_SP_DATA, 1'b0, 16'hb123, S_DAT);
        do_req(EMSD_SP_DATA, 1'b1, 1'b0, ADDR_GLOBAL_SPACE_ALLOCATION, 16'h0000, S_INT);
        b0_in_program = 1'b1;
        wr_rd(EMSD_SP_PROG, 1'b0, B0_PROG_BASE, S_INT);
        wr_rd(EMSD_SP_DATA, 1'b0, B0_DATA_BASE, S_DAT);
        wr_rd(EMSD_SP_PROG, 1'b0, 16'hfeff, S_PRG);
        b0_in_program = 1'b0;
        wr_rd(EMSD_SP_PROG, 1'b0, B0_PROG_BASE + 16'hff, S_PRG);
        wr_rd(EMSD_SP_DATA, 1'b0, B0_DATA_BASE + 16'hff, S_INT);
        wr_rd(EMSD_SP_DATA, 1'b0, B1_BASE + 16'hff, S_INT);
        wr_rd(EMSD_SP_PROG, 1'b0, B1_BASE, S_PRG);
        wr_rd(EMSD_SP_DATA, 1'b0, B2_BASE, S_INT);
        wr_rd(EMSD_SP_DATA, 1'b0, 16'h007f, S_INT);
        wr_rd(EMSD_SP_DATA, 1'b0, 16'h0400, S_DAT);
        wr_rd(EMSD_SP_PROG, 1'b0, 16'h0000, S_PRG);
        for (int i = 0; i < 6; i++) begin
            page_pointer = {1'b1, 8'($random(seed))};
            a = {page_pointer, 7'($random(seed))};
            wr_rd(EMSD_SP_DATA, 1'b1, a, S_DAT);
            wr_rd(EMSD_SP_IO, 1'b0, 16'($random(seed)), S_IO);
        end
        for (int i = 0; i < 40 && exp_q.size() != 0; i++)
            @(negedge core_clk);
        check(32'(exp_q.size()), 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
